// ==== hw/rsr_pkg.sv ====
/*
  rsr_pkg: register offsets, field widths, state codes and carrier structs
  for the radio status readback bank. Assumes nothing beyond the compiler.
*/
package rsr_pkg;
  // register offsets on the serial control port address space
  localparam logic [5:0] ADDR_CHIP_REVISION = 6'h31;
  localparam logic [5:0] ADDR_RADIO_STATE = 6'h35;
  localparam logic [5:0] ADDR_OUTPUT_PIN_STATUS = 6'h38;
  localparam logic [5:0] ADDR_SYNTH_TUNE_READBACK = 6'h39;
  localparam logic [5:0] ADDR_TX_QUEUE_LEVEL = 6'h3A;
  // value returned for unmapped addresses and reset value of read data
  localparam logic [7:0] READ_DEFAULT = 8'h00;
  // revision code, arbitrary neutral value
  localparam logic [7:0] CHIP_REVISION_DEFAULT = 8'h5A;
  // field widths
  localparam int STATE_CODE_W = 5;
  localparam int FILL_COUNT_W = 7;
  localparam int RSVD_STATE_W = 3;
  localparam int RSVD_PIN_W = 6;
  // radio state codes
  localparam logic [4:0] ST_SLEEP = 5'h00;
  localparam logic [4:0] ST_IDLE = 5'h01;
  localparam logic [4:0] ST_OSCILLATOR_OFF = 5'h02;
  localparam logic [4:0] ST_MANUAL_CAL_OSC_ON = 5'h03;
  localparam logic [4:0] ST_MANUAL_CAL_REGULATOR_ON = 5'h04;
  localparam logic [4:0] ST_MANUAL_CALIBRATION = 5'h05;
  localparam logic [4:0] ST_WAKEUP_OSC_ON = 5'h06;
  localparam logic [4:0] ST_WAKEUP_REGULATOR_ON = 5'h07;
  localparam logic [4:0] ST_CALIBRATION_START = 5'h08;
  localparam logic [4:0] ST_LOOP_BANDWIDTH_BOOST = 5'h09;
  localparam logic [4:0] ST_SYNTH_LOCK = 5'h0A;
  localparam logic [4:0] ST_CONVERTER_POWER_UP = 5'h0B;
  localparam logic [4:0] ST_CALIBRATION_END = 5'h0C;
  localparam logic [4:0] ST_RX = 5'h0D;
  localparam logic [4:0] ST_RX_END = 5'h0E;
  localparam logic [4:0] ST_RX_RESTART = 5'h0F;
  localparam logic [4:0] ST_TX_TO_RX_TURNAROUND = 5'h10;
  localparam logic [4:0] ST_RX_OVERFLOW = 5'h11;
  localparam logic [4:0] ST_SYNTH_READY_FOR_TRANSMIT = 5'h12;
  localparam logic [4:0] ST_TX = 5'h13;
  localparam logic [4:0] ST_TX_END = 5'h14;
  localparam logic [4:0] ST_RX_TO_TX_TURNAROUND = 5'h15;
  localparam logic [4:0] ST_TX_UNDERFLOW = 5'h16;
  localparam logic [4:0] ST_LAST_CODE = 5'h16;

  // live conditions sampled from the rest of the device
  typedef struct packed {
    logic [4:0] radioStateCode;
    logic generalOutputPinOne;
    logic generalOutputPinZero;
    logic [7:0] synthTuningValue;
    logic txQueueUnderrunFlag;
    logic [6:0] txQueueFillCount;
  } rsr_status_t;

  // register access request from the serial control port
  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rsr_req_t;
endpackage

// ==== hw/radio_status_readback.sv ====
/*
  radio_status_readback: read-only status bank of the packet radio transmitter.
  Assumes the serial control port front end delivers one access per cycle as a
  request struct, and the live status inputs are synchronous to sys_clk.
*/
// Summary of operation
// - chip revision code readable in bits 7:0
// - radio state code in 4:0, 7:5 zero
// - state codes 13 to 22 for rx/tx phases
// - output pin levels in bits 1 and 0
// - synthesizer tuning value readable, test use only
// - bit 7 flags transmit queue underrun
// - bits 6:0 give transmit queue fill count
`timescale 1ns/1ps
module radio_status_readback
  import rsr_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // control port access
  input wire rsr_req_t portReq,
  output logic [7:0] readData,
  output logic readValid,
  // live device conditions
  input wire rsr_status_t liveStatus
);

  logic [7:0] readData_r;
  logic [7:0] readData_nxt;
  logic readValid_r;
  logic readValid_nxt;

  // clamp codes outside the documented table to zero, keep 7:5 clear
  function automatic logic [7:0] state_field(input logic [4:0] code);
    logic [7:0] f;
    f = READ_DEFAULT;
    if (code <= ST_LAST_CODE) begin
      f = {{RSVD_STATE_W{1'b0}}, code};
    end
    return f;
  endfunction

  // read decode; writes produce no change anywhere
  always_comb begin
    readData_nxt = readData_r;
    readValid_nxt = 1'b0;
    if (portReq.valid && !portReq.write) begin
      readValid_nxt = 1'b1;
      if (portReq.addr == ADDR_CHIP_REVISION) begin
        readData_nxt = CHIP_REVISION_DEFAULT;
      end else if (portReq.addr == ADDR_RADIO_STATE) begin
        readData_nxt = state_field(liveStatus.radioStateCode);
      end else if (portReq.addr == ADDR_OUTPUT_PIN_STATUS) begin
        readData_nxt = {{RSVD_PIN_W{1'b0}}, liveStatus.generalOutputPinOne,
                        liveStatus.generalOutputPinZero};
      end else if (portReq.addr == ADDR_SYNTH_TUNE_READBACK) begin
        readData_nxt = liveStatus.synthTuningValue;
      end else if (portReq.addr == ADDR_TX_QUEUE_LEVEL) begin
        readData_nxt = {liveStatus.txQueueUnderrunFlag, liveStatus.txQueueFillCount};
      end else begin
        readData_nxt = READ_DEFAULT;
      end
    end
  end

  // registered read answer
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      readData_r <= READ_DEFAULT;
      readValid_r <= 1'b0;
    end else if (clkEn) begin
      readData_r <= readData_nxt;
      readValid_r <= readValid_nxt;
    end
  end

  assign readData = readData_r;
  assign readValid = readValid_r;

  // helpers: the kinds of request that the bank can see at an enabled edge
  // a read of one given address taken at this edge
  sequence s_read(logic [5:0] a);
    clkEn && portReq.valid && !portReq.write && portReq.addr == a;
  endsequence

  // a read taken at this edge, whatever the address
  sequence s_any_read;
    clkEn && portReq.valid && !portReq.write;
  endsequence

  // a write presented while the enable is high
  sequence s_write;
    clkEn && portReq.valid && portReq.write;
  endsequence

  // an enabled edge that carries no read at all
  sequence s_idle_edge;
    clkEn && !(portReq.valid && !portReq.write);
  endsequence

  // true for the five addresses that the bank decodes
  function automatic logic addr_mapped(input logic [5:0] a);
    logic hit;
    hit = 1'b0;
    if (a == ADDR_CHIP_REVISION) begin
      hit = 1'b1;
    end else if (a == ADDR_RADIO_STATE) begin
      hit = 1'b1;
    end else if (a == ADDR_OUTPUT_PIN_STATUS) begin
      hit = 1'b1;
    end else if (a == ADDR_SYNTH_TUNE_READBACK) begin
      hit = 1'b1;
    end else if (a == ADDR_TX_QUEUE_LEVEL) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // a read of an address outside the bank
  sequence s_unmapped_read;
    s_any_read ##0 !addr_mapped(portReq.addr);
  endsequence

  // a read of an address inside the bank
  sequence s_mapped_read;
    s_any_read ##0 addr_mapped(portReq.addr);
  endsequence

  // a radio state read while the machine reports a code within lo..hi
  sequence s_state_in(logic [4:0] lo, logic [4:0] hi);
    s_read(ADDR_RADIO_STATE) ##0 (liveStatus.radioStateCode >= lo && liveStatus.radioStateCode <= hi);
  endsequence

  // a radio state read while the machine reports a code beyond the table
  sequence s_state_unlisted;
    s_read(ADDR_RADIO_STATE) ##0 liveStatus.radioStateCode > ST_LAST_CODE;
  endsequence

  a_revision_read: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_read(ADDR_CHIP_REVISION) |=> readValid && readData == CHIP_REVISION_DEFAULT)
    else $error("revision readback wrong");
  a_state_reserved: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_read(ADDR_RADIO_STATE) |=> readData[7:5] == 3'h0)
    else $error("state reserved bits not zero");
  a_state_low_codes: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_state_in(ST_SLEEP, ST_CALIBRATION_END) |=> readData[4:0] == $past(liveStatus.radioStateCode))
    else $error("setup state code wrong");
  a_state_high_codes: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_state_in(ST_RX, ST_TX_UNDERFLOW) |=> readData[4:0] == $past(liveStatus.radioStateCode))
    else $error("rx tx state code wrong");
  a_pin_levels: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_read(ADDR_OUTPUT_PIN_STATUS) |=> readData == {6'h00, $past(liveStatus.generalOutputPinOne),
    $past(liveStatus.generalOutputPinZero)})
    else $error("pin status wrong");
  a_tune_value: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_read(ADDR_SYNTH_TUNE_READBACK) |=> readData == $past(liveStatus.synthTuningValue))
    else $error("tuning readback wrong");
  a_underrun_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_read(ADDR_TX_QUEUE_LEVEL) |=> readData[7] == $past(liveStatus.txQueueUnderrunFlag))
    else $error("underrun flag wrong");
  a_fill_count: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_read(ADDR_TX_QUEUE_LEVEL) |=> readData[6:0] == $past(liveStatus.txQueueFillCount))
    else $error("fill count wrong");
  a_write_ignored: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && portReq.valid && portReq.write |=> !readValid && $stable(readData))
    else $error("write disturbed readback");

  // radio state codes beyond the table read as zero
  a_state_clamp: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_state_unlisted |=> readValid && readData == READ_DEFAULT)
    else $error("unlisted state code not cleared");

  // a radio state read is answered one enabled cycle later
  a_state_answered: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_read(ADDR_RADIO_STATE) |=> readValid)
    else $error("state read not answered");

  // pin status reserved bits stay clear
  a_pin_reserved: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_read(ADDR_OUTPUT_PIN_STATUS) |=> readData[7:2] == {RSVD_PIN_W{1'b0}})
    else $error("pin reserved bits not zero");

  // tuning readback is answered like any other register
  a_tune_answered: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_read(ADDR_SYNTH_TUNE_READBACK) |=> readValid)
    else $error("tuning read not answered");

  // queue status byte carries flag and count together
  a_queue_byte: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_read(ADDR_TX_QUEUE_LEVEL) |=> readValid && readData == {$past(liveStatus.txQueueUnderrunFlag),
    $past(liveStatus.txQueueFillCount)})
    else $error("queue status byte wrong");

  // every mapped read gets an answer pulse
  a_mapped_answer: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_mapped_read |=> readValid)
    else $error("mapped read not answered");

  // unmapped reads are answered with the default byte
  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_unmapped_read |=> readValid && readData == READ_DEFAULT)
    else $error("unmapped read not zero");

  // no answer pulse without a read on the edge before
  a_valid_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_idle_edge |=> !readValid)
    else $error("answer pulse without read");

  // last answer byte holds between reads
  a_data_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_idle_edge |=> $stable(readData))
    else $error("answer byte changed without read");

  // enable low freezes the whole bank unless reset is asserted
  a_enable_freeze: assert property (@(posedge sys_clk) disable iff (!rstn)
    !clkEn |=> $stable(readData) && $stable(readValid))
    else $error("state moved with enable low");

  // reset clears the answer whatever the enable does
  a_reset_clears: assert property (@(posedge sys_clk) !rstn |=> readData == READ_DEFAULT && !readValid)
    else $error("reset did not clear answer");
endmodule

// ==== tb/rsr_host.sv ====
/*
  rsr_host: host side of the serial control port, issuing single accesses.
  Assumes the bank answers a read one enabled cycle after taking it.
*/
`timescale 1ns/1ps
module rsr_host
  import rsr_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // answer from the bank
  input wire logic [7:0] readData,
  input wire logic readValid,
  // request to the bank
  output rsr_req_t portReq
);
  initial portReq = '{1'b0, 1'b0, 6'h00, 8'hFF};
  // one access held for one edge; answer sampled after the next edge
  task automatic access(input logic wr, input logic [5:0] a, output logic ok, output logic [7:0] d);
    @(posedge sys_clk);
    portReq <= '{1'b1, wr, a, 8'hFF};
    @(posedge sys_clk);
    portReq <= '{1'b0, 1'b0, ~a, 8'h00}; // released lines show a new pattern
    #1;
    ok = readValid;
    d = readData;
  endtask
endmodule

// ==== tb/radio_status_readback_tb.sv ====
/*
  radio_status_readback_tb: table of register reads, then state codes,
  ignored writes, a frozen enable and a mid-run reset. Assumes a 100 MHz clock.
*/
`timescale 1ns/1ps
module radio_status_readback_tb;
  import rsr_pkg::*;
  typedef struct {logic [5:0] a; rsr_status_t s; logic [7:0] e;} rsr_row_t;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic clkEn = 1'b1;
  rsr_req_t portReq;
  rsr_status_t liveStatus = '0;
  logic [7:0] readData, got;
  logic readValid, ok;
  int n_fail = 0;
  int comparisons = 0;
  // address, live levels, expected byte
  rsr_row_t rows[7] = '{
    '{ADDR_CHIP_REVISION, 23'h7FFFFF, CHIP_REVISION_DEFAULT},
    '{ADDR_OUTPUT_PIN_STATUS, 23'h720000, 8'h02},
    '{ADDR_OUTPUT_PIN_STATUS, 23'h0DFFFF, 8'h01},
    '{ADDR_SYNTH_TUNE_READBACK, 23'h00C300, 8'hC3},
    '{ADDR_TX_QUEUE_LEVEL, 23'h0000C0, 8'hC0},
    '{ADDR_TX_QUEUE_LEVEL, 23'h7FFF7F, 8'h7F},
    '{6'h30, 23'h7FFFFF, 8'h00}};
  always #5 sys_clk = ~sys_clk;
  radio_status_readback dut(.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .portReq(portReq),
    .readData(readData), .readValid(readValid), .liveStatus(liveStatus));
  rsr_host host(.sys_clk(sys_clk), .readData(readData), .readValid(readValid), .portReq(portReq));
  // byte comparison
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t byte %h expected %h", $time, g, e);
    end
  endtask
  // flag comparison
  task automatic chkBit(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  // set live levels, read one address, check answer
  task automatic rd(input logic [5:0] a, input rsr_status_t s, input logic [7:0] e);
    @(posedge sys_clk);
    liveStatus <= s;
    host.access(1'b0, a, ok, got);
    chkBit(ok, 1'b1);
    chk(got, e);
  endtask
  task automatic results;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_fail++;
    results();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    chk(readData, READ_DEFAULT);
    chkBit(readValid, 1'b0);
    foreach (rows[i]) rd(rows[i].a, rows[i].s, rows[i].e);
    for (int c = 0; c < 25; c++) begin
      rd(ADDR_RADIO_STATE, {c[4:0], 18'h3FFFF}, c < 23 ? 8'(c) : 8'h00);
    end
    // writes are neither answered nor change the last read byte
    rd(ADDR_SYNTH_TUNE_READBACK, 23'h005C00, 8'h5C);
    host.access(1'b1, ADDR_SYNTH_TUNE_READBACK, ok, got);
    chkBit(ok, 1'b0);
    chk(got, 8'h5C);
    rd(ADDR_SYNTH_TUNE_READBACK, 23'h00A700, 8'hA7);
    // a read presented while the enable is low is not taken
    @(posedge sys_clk);
    clkEn <= 1'b0;
    host.access(1'b0, ADDR_TX_QUEUE_LEVEL, ok, got);
    chkBit(ok, 1'b0);
    chk(got, 8'hA7);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    // reset in mid-run clears the answer
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(readData, READ_DEFAULT);
    chkBit(readValid, 1'b0);
    @(posedge sys_clk);
    rstn <= 1'b1;
    rd(ADDR_TX_QUEUE_LEVEL, 23'h000081, 8'h81);
    results();
  end
endmodule
